/* hw/pcih_config_header.v */
// Behaviour
// RULE_01 - silicon revision reads back; only eeprom load changes it, host writes dropped
// RULE_02 - 24-bit class code from eeprom only, defaults base 06h, sub 80h, interface 00h
// RULE_03 - cache line size byte is read/write, resets zero, steers nothing
// RULE_04 - latency timer byte reads zero, writes ignored
// RULE_05 - header type layout bits 6:0 read zero, read-only
// RULE_06 - header type bit 7 reads zero, single function
// RULE_07 - self test byte reads zero, writes ignored
// RULE_08 - memory base bits 3:0 fixed zero: memory, 32-bit, not prefetchable
// RULE_09 - memory base claims 128 bytes; 6:4 zero, 31:7 writable, reset zero
// RULE_10 - io base bit 0 reads one, bit 1 reads zero, both read-only
// RULE_11 - io base claims 128 bytes; 6:2 zero, 31:7 writable, reset zero
// RULE_12 - control bits 13:12 enable memory and io base decoding
// RULE_13 - claim access when enabled and addr 31:7 match; 6:0 select register
// RULE_14 - writes to fixed bits discarded; reads return fixed or loaded values
`include "pcih_consts.vh"

module pcih_config_header #(
    parameter [7:0]  REVISION_DEFAULT = `PCIH_REV_RESET,
    parameter [23:0] CLASS_DEFAULT    = `PCIH_CLASS_RESET,
    parameter        WIN_LSB          = `PCIH_BAR_BASE_LSB
) (
    input  wire                mclk,
    input  wire                reset_n,
    // configuration access from the host
    input  wire                cfg_req,
    input  wire                cfg_write,
    input  wire [7:2]          cfg_dword,
    input  wire [3:0]          cfg_byte_en,
    input  wire [31:0]         cfg_wdata,
    output wire                cfg_ack,
    output wire                cfg_claim,
    output wire [31:0]         cfg_rdata,
    // serial eeprom load of identity fields
    input  wire                eeprom_load,
    input  wire [7:0]          eeprom_revision,
    input  wire [23:0]         eeprom_class,
    // local control register bits
    input  wire [15:0]         local_control_register,
    // memory and io space accesses
    input  wire                acc_valid,
    input  wire                acc_is_io,
    input  wire [31:0]         acc_addr,
    output wire                acc_claim,
    output wire                acc_claim_io,
    output wire [WIN_LSB-1:0]  acc_reg_index,
    // current base values for the rest of the device
    output wire [31:0]         cfg_memory_base,
    output wire [31:0]         cfg_io_base
);

    // ****************************************************************
    // dword indices of the slice
    // ****************************************************************
    // byte offsets kept at full width; the dword index drops the lane bits
    localparam [7:0] OFS_ID     = `PCIH_OFS_REVISION;
    localparam [7:0] OFS_MISC   = `PCIH_OFS_CACHE_LINE;
    localparam [7:0] OFS_MEMBAR = `PCIH_OFS_MEM_BASE;
    localparam [7:0] OFS_IOBAR  = `PCIH_OFS_IO_BASE;

    localparam [5:0] DW_ID      = OFS_ID[7:2];
    localparam [5:0] DW_MISC    = OFS_MISC[7:2];
    localparam [5:0] DW_MEMBAR  = OFS_MEMBAR[7:2];
    localparam [5:0] DW_IOBAR   = OFS_IOBAR[7:2];

    // read mux groups; both base registers share one branch
    localparam [1:0] SEL_NONE   = 2'h0;
    localparam [1:0] SEL_ID     = 2'h1;
    localparam [1:0] SEL_MISC   = 2'h2;
    localparam [1:0] SEL_BAR    = 2'h3;

    // ****************************************************************
    // decode helpers
    // ****************************************************************
    function dword_is;
        input [5:0] dw;
        input [5:0] target;
        begin
            dword_is = (dw == target);
        end
    endfunction

    function [1:0] dword_sel;
        input [5:0] dw;
        begin
            if (dword_is(dw, DW_ID)) begin
                dword_sel = SEL_ID;
            end else if (dword_is(dw, DW_MISC)) begin
                dword_sel = SEL_MISC;
            end else if (dword_is(dw, DW_MEMBAR) || dword_is(dw, DW_IOBAR)) begin
                dword_sel = SEL_BAR;
            end else begin
                dword_sel = SEL_NONE;
            end
        end
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    reg  [7:0]          revision_reg;
    reg  [23:0]         class_reg;
    reg                 ack_reg;
    reg                 claim_reg;
    reg  [31:0]         rdata_reg;
    reg  [31:0]         rdata_next;
    reg                 acc_claim_reg;
    reg                 acc_claim_io_reg;
    reg  [WIN_LSB-1:0]  acc_index_reg;
    reg  [WIN_LSB-1:0]  acc_index_next;
    reg  [31:0]         mem_base_out_reg;
    reg  [31:0]         io_base_out_reg;

    wire [1:0]          sel;
    wire                wr_misc;
    wire                wr_mem;
    wire                wr_io;
    wire [31:0]         misc_q;
    wire [31:0]         mem_q;
    wire [31:0]         io_q;
    wire [31:0]         id_word;
    wire [31:0]         misc_word;
    wire                cfg_rd;
    wire                cfg_wr;
    wire                cfg_in_slice;
    wire [7:0]          cls_byte;
    wire [7:0]          lat_byte;
    wire [6:0]          hdr_layout;
    wire                hdr_multi;
    wire [7:0]          hdr_byte;
    wire [7:0]          bist_byte;
    wire [1:0]          win_en;
    wire [1:0]          win_space;
    wire [1:0]          win_hit;
    wire [63:0]         win_base;
    wire [2*WIN_LSB-1:0] win_ofs;

    assign sel = dword_sel(cfg_dword);
    assign cfg_in_slice = (sel != SEL_NONE);
    assign cfg_wr = cfg_req & cfg_write;
    assign cfg_rd = cfg_req & ~cfg_write;

    // ****************************************************************
    // identity fields: eeprom only
    // ****************************************************************
    // host writes to the id dword have no write path at all
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            revision_reg <= REVISION_DEFAULT;
            class_reg    <= CLASS_DEFAULT;
        end else if (eeprom_load) begin
            revision_reg <= eeprom_revision; // [RULE_01]
            class_reg    <= eeprom_class;    // [RULE_02]
        end
    end

    assign id_word[`PCIH_REV_LSB +: 8]    = revision_reg;   // [RULE_01]
    assign id_word[`PCIH_CLASS_LSB +: 24] = class_reg;      // [RULE_02]

    // ****************************************************************
    // writable registers
    // ****************************************************************
    assign wr_misc = cfg_wr & dword_is(cfg_dword, DW_MISC);
    assign wr_mem  = cfg_wr & dword_is(cfg_dword, DW_MEMBAR);
    assign wr_io   = cfg_wr & dword_is(cfg_dword, DW_IOBAR);

    // only the cache line byte takes writes; the upper three bytes stay zero
    pcih_masked_reg #(
        .WMASK (`PCIH_DW3_WMASK),
        .RESET (`PCIH_DW3_RESET)
    ) u_misc (
        .mclk    (mclk),
        .reset_n (reset_n),
        .wr      (wr_misc),     // [RULE_03] [RULE_04] [RULE_07]
        .byte_en (cfg_byte_en),
        .wdata   (cfg_wdata),
        .q       (misc_q)
    );

    // base bits 31:7 only; the low bits keep their reset pattern
    pcih_masked_reg #(
        .WMASK (`PCIH_BAR_WMASK),
        .RESET (`PCIH_MEM_BASE_RESET)
    ) u_mem_base (
        .mclk    (mclk),
        .reset_n (reset_n),
        .wr      (wr_mem),      // [RULE_08] [RULE_09] [RULE_14]
        .byte_en (cfg_byte_en),
        .wdata   (cfg_wdata),
        .q       (mem_q)
    );

    pcih_masked_reg #(
        .WMASK (`PCIH_BAR_WMASK),
        .RESET (`PCIH_IO_BASE_RESET)
    ) u_io_base (
        .mclk    (mclk),
        .reset_n (reset_n),
        .wr      (wr_io),       // [RULE_10] [RULE_11] [RULE_14]
        .byte_en (cfg_byte_en),
        .wdata   (cfg_wdata),
        .q       (io_q)
    );

    // ****************************************************************
    // cache line, latency, header type and self test bytes
    // ****************************************************************
    // fixed bytes are rebuilt from constants so nothing can leak in
    assign cls_byte   = misc_q[`PCIH_CLS_LSB +: 8];    // [RULE_03]
    assign lat_byte   = 8'h00;                         // [RULE_04]
    assign hdr_layout = 7'h00;                         // [RULE_05]
    assign hdr_multi  = 1'b0;                          // [RULE_06]
    assign hdr_byte   = {hdr_multi, hdr_layout};
    assign bist_byte  = 8'h00;                         // [RULE_07]

    assign misc_word[`PCIH_CLS_LSB +: 8]  = cls_byte;
    assign misc_word[`PCIH_LAT_LSB +: 8]  = lat_byte;
    assign misc_word[`PCIH_HDR_LSB +: 8]  = hdr_byte;
    assign misc_word[`PCIH_BIST_LSB +: 8] = bist_byte;

    // ****************************************************************
    // configuration read path
    // ****************************************************************
    always @* begin
        rdata_next = 32'h00000000;
        case (sel)
            SEL_ID: begin
                rdata_next = id_word;
            end
            SEL_MISC: begin
                rdata_next = misc_word;
            end
            SEL_BAR: begin
                if (dword_is(cfg_dword, DW_MEMBAR)) begin
                    rdata_next = mem_q;     // [RULE_08] [RULE_09]
                end else begin
                    rdata_next = io_q;      // [RULE_10] [RULE_11]
                end
            end
            default: begin
                rdata_next = 32'h00000000;
            end
        endcase
    end

    // every request answers one cycle later, claimed or not
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ack_reg   <= 1'b0;
            claim_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
        end else begin
            ack_reg   <= cfg_req;
            claim_reg <= cfg_req & cfg_in_slice;
            // a write answers zero so stale read data never looks fresh
            if (cfg_rd) begin
                rdata_reg <= rdata_next;    // [RULE_14]
            end else if (cfg_wr) begin
                rdata_reg <= 32'h00000000;
            end
        end
    end

    // ****************************************************************
    // window decode
    // ****************************************************************
    assign win_en[0]    = local_control_register[`PCIH_CTRL_MEM_EN_BIT]; // [RULE_12]
    assign win_en[1]    = local_control_register[`PCIH_CTRL_IO_EN_BIT];  // [RULE_12]
    assign win_space[0] = ~acc_is_io;
    assign win_space[1] = acc_is_io;
    assign win_base[31:0]  = mem_q;
    assign win_base[63:32] = io_q;

    genvar w;
    generate
        for (w = 0; w < 2; w = w + 1) begin : g_win
            pcih_bar_match #(
                .LSB (WIN_LSB)
            ) u_match (
                .enable   (win_en[w]),
                .valid    (acc_valid),
                .space_ok (win_space[w]),
                .addr     (acc_addr),
                .base     (win_base[w*32+WIN_LSB +: 32-WIN_LSB]),
                .hit      (win_hit[w]),                       // [RULE_13]
                .offset   (win_ofs[w*WIN_LSB +: WIN_LSB])
            );
        end
    endgenerate

    // memory window first; the space bit keeps both from hitting at once
    always @* begin
        acc_index_next = {WIN_LSB{1'b0}};
        if (win_hit[0]) begin
            acc_index_next = win_ofs[WIN_LSB-1:0];
        end else if (win_hit[1]) begin
            acc_index_next = win_ofs[2*WIN_LSB-1:WIN_LSB];
        end
    end

    // claims are registered so the outputs come from flops
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            acc_claim_reg    <= 1'b0;
            acc_claim_io_reg <= 1'b0;
            acc_index_reg    <= {WIN_LSB{1'b0}};
        end else begin
            acc_claim_reg    <= |win_hit;           // [RULE_13]
            acc_claim_io_reg <= win_hit[1];
            // index holds between hits for the local side
            if (|win_hit) begin
                acc_index_reg <= acc_index_next;    // [RULE_13]
            end
        end
    end

    // ****************************************************************
    // base values seen by the rest of the device
    // ****************************************************************
    // one edge behind the registers; the window decode uses the live values
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mem_base_out_reg <= `PCIH_MEM_BASE_RESET;
            io_base_out_reg  <= `PCIH_IO_BASE_RESET;
        end else begin
            mem_base_out_reg <= mem_q;
            io_base_out_reg  <= io_q;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign cfg_ack         = ack_reg;
    assign cfg_claim       = claim_reg;
    assign cfg_rdata       = rdata_reg;
    assign acc_claim       = acc_claim_reg;
    assign acc_claim_io    = acc_claim_io_reg;
    assign acc_reg_index   = acc_index_reg;
    assign cfg_memory_base = mem_base_out_reg;
    assign cfg_io_base     = io_base_out_reg;

endmodule

/* hw/pcih_consts.vh */
`ifndef PCIH_CONSTS_VH
`define PCIH_CONSTS_VH

// ****************************************************************
// byte offsets of the header slice
// ****************************************************************
`define PCIH_OFS_REVISION     8'h08
`define PCIH_OFS_CLASS        8'h09
`define PCIH_OFS_CACHE_LINE   8'h0C
`define PCIH_OFS_LATENCY      8'h0D
`define PCIH_OFS_HEADER_TYPE  8'h0E
`define PCIH_OFS_SELF_TEST    8'h0F
`define PCIH_OFS_MEM_BASE     8'h10
`define PCIH_OFS_IO_BASE      8'h14

// ****************************************************************
// field positions
// ****************************************************************
`define PCIH_REV_LSB          0
`define PCIH_CLASS_LSB        8
`define PCIH_CLS_LSB          0
`define PCIH_LAT_LSB          8
`define PCIH_HDR_LSB          16
`define PCIH_HDR_MULTI_BIT    23
`define PCIH_BIST_LSB         24
`define PCIH_BAR_BASE_LSB     7
`define PCIH_BAR_SPACE_BIT    0
`define PCIH_CTRL_MEM_EN_BIT  12
`define PCIH_CTRL_IO_EN_BIT   13

// ****************************************************************
// writable masks and reset values
// ****************************************************************
`define PCIH_DW3_WMASK        32'h000000FF
`define PCIH_DW3_RESET        32'h00000000
`define PCIH_BAR_WMASK        32'hFFFFFF80
`define PCIH_MEM_BASE_RESET   32'h00000000
`define PCIH_IO_BASE_RESET    32'h00000001
`define PCIH_CLASS_RESET      24'h068000
`define PCIH_REV_RESET        8'h01

`endif

/* hw/pcih_masked_reg.v */
// ****************************************************************
// dword register with per-bit write mask and byte enables
// ****************************************************************
module pcih_masked_reg #(
    parameter [31:0] WMASK = 32'hFFFFFFFF,
    parameter [31:0] RESET = 32'h00000000
) (
    input  wire        mclk,
    input  wire        reset_n,
    input  wire        wr,
    input  wire [3:0]  byte_en,
    input  wire [31:0] wdata,
    output wire [31:0] q
);
    reg  [31:0] q_reg;
    wire [31:0] lane_mask;
    wire [31:0] bit_mask;

    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_lane
            assign lane_mask[i*8 +: 8] = {8{byte_en[i]}};
        end
    endgenerate

    // bits outside WMASK never move off their reset value
    assign bit_mask = lane_mask & WMASK;

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            q_reg <= RESET;
        end else if (wr) begin
            q_reg <= (q_reg & ~bit_mask) | (wdata & bit_mask);
        end
    end

    assign q = q_reg;
endmodule

/* hw/pcih_bar_match.v */
// ****************************************************************
// window compare for one base register
// ****************************************************************
module pcih_bar_match #(
    parameter LSB = 7
) (
    input  wire             enable,
    input  wire             valid,
    input  wire             space_ok,
    input  wire [31:0]      addr,
    input  wire [31:LSB]    base,
    output wire             hit,
    output wire [LSB-1:0]   offset
);
    assign hit    = enable & valid & space_ok & (addr[31:LSB] == base);
    assign offset = addr[LSB-1:0];
endmodule

/* test/pcih_props.sv */
// ****************************************************************
// protocol and register checks at the header ports
// ****************************************************************
module pcih_props #(
    parameter WIN_LSB = 7
) (
    input wire               mclk,
    input wire               reset_n,
    input wire               cfg_req,
    input wire               cfg_write,
    input wire [7:2]         cfg_dword,
    input wire               cfg_ack,
    input wire               cfg_claim,
    input wire [31:0]        cfg_rdata,
    input wire [15:0]        local_control_register,
    input wire               acc_valid,
    input wire               acc_is_io,
    input wire [31:0]        acc_addr,
    input wire               acc_claim,
    input wire               acc_claim_io,
    input wire [WIN_LSB-1:0] acc_reg_index,
    input wire [31:0]        cfg_memory_base,
    input wire [31:0]        cfg_io_base
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    sequence s_rd3;
        cfg_req && !cfg_write && cfg_dword == 6'h03;
    endsequence
    // base outputs lag a write by one edge, so skip that edge
    sequence s_mem_hit;
        acc_valid && !acc_is_io && local_control_register[12] && !$past(cfg_req)
            && acc_addr[31:7] == cfg_memory_base[31:7];
    endsequence
    sequence s_io_hit;
        acc_valid && acc_is_io && local_control_register[13] && !$past(cfg_req)
            && acc_addr[31:7] == cfg_io_base[31:7];
    endsequence

    AST_ACK: assert property (cfg_req |=> cfg_ack)
        else $error("no ack after request");
    AST_CLAIM: assert property (cfg_req |=> cfg_claim ==
        ($past(cfg_dword) >= 6'h02 && $past(cfg_dword) <= 6'h05))
        else $error("claim does not match slice");
    AST_RDATA_HOLD: assert property (!cfg_req |=> $stable(cfg_rdata))
        else $error("read data moved without request");
    AST_DW3_FIXED: assert property (
        s_rd3 |=> cfg_rdata[31:8] == 24'h000000)
        else $error("fixed bytes of dword 3 not zero");
    AST_MEM_LOW: assert property (cfg_memory_base[6:0] == 7'h00)
        else $error("memory base low bits not zero");
    AST_IO_LOW: assert property (cfg_io_base[6:0] == 7'h01)
        else $error("io base low bits wrong");
    AST_MEM_HIT: assert property (s_mem_hit |=> acc_claim && !acc_claim_io
        && acc_reg_index == $past(acc_addr[WIN_LSB-1:0]))
        else $error("memory window hit not claimed");
    AST_IO_HIT: assert property (s_io_hit |=> acc_claim && acc_claim_io
        && acc_reg_index == $past(acc_addr[WIN_LSB-1:0]))
        else $error("io window hit not claimed");
    AST_NO_STRAY: assert property (acc_claim |-> $past(acc_valid &&
        (acc_is_io ? local_control_register[13] : local_control_register[12])))
        else $error("claim without enabled access");
endmodule

/* test/pcih_host_model.sv */
// ****************************************************************
// host side: configuration cycles and window accesses
// ****************************************************************
module pcih_host_model (
    input  wire        mclk,
    output logic       cfg_req,
    output logic       cfg_write,
    output logic [7:2] cfg_dword,
    output logic [3:0] cfg_byte_en,
    output logic [31:0] cfg_wdata,
    input  wire        cfg_ack,
    input  wire        cfg_claim,
    input  wire [31:0] cfg_rdata,
    output logic       acc_valid,
    output logic       acc_is_io,
    output logic [31:0] acc_addr,
    input  wire        acc_claim,
    input  wire        acc_claim_io,
    input  wire [6:0]  acc_reg_index
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cfg_req = 1'b0;
        cfg_write = 1'b0;
        cfg_dword = 6'h00;
        cfg_byte_en = 4'h0;
        cfg_wdata = 32'h00000000;
        acc_valid = 1'b0;
        acc_is_io = 1'b0;
        acc_addr = 32'h00000000;
    end
    // released lines show the inverse so stale data never matches by luck
    task automatic cfg(input logic w, input logic [7:2] dw, input logic [3:0] be,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic cl, output logic ok);
        int n;
        @(negedge mclk);
        cfg_req = 1'b1;
        cfg_write = w;
        cfg_dword = dw;
        cfg_byte_en = be;
        cfg_wdata = wd;
        @(negedge mclk);
        cfg_req = 1'b0;
        cfg_dword = ~dw;
        cfg_wdata = ~wd;
        ok = 1'b0;
        for (n = 0; n < 2 && !ok; n++) begin
            if (cfg_ack === 1'b1) begin
                ok = 1'b1;
                rd = cfg_rdata;
                cl = cfg_claim;
            end else begin
                @(negedge mclk);
            end
        end
    endtask
    task automatic acc(input logic io, input logic [31:0] a, output logic [31:0] r);
        @(negedge mclk);
        acc_valid = 1'b1;
        acc_is_io = io;
        acc_addr = a;
        @(negedge mclk);
        acc_valid = 1'b0;
        acc_addr = ~a;
        r = {23'h000000, acc_claim, acc_claim_io, acc_reg_index};
    endtask
endmodule

/* test/test_pcih_config_header.sv */
module test_pcih_config_header;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic cfg_req, cfg_write, cfg_ack, cfg_claim, eeprom_load, acc_valid, acc_is_io;
    logic acc_claim, acc_claim_io, c, k;
    logic [7:2] cfg_dword;
    logic [3:0] cfg_byte_en;
    logic [31:0] cfg_wdata, cfg_rdata, acc_addr, cfg_memory_base, cfg_io_base, d;
    logic [7:0] eeprom_revision = 8'h00;
    logic [23:0] eeprom_class = 24'h000000;
    logic [15:0] local_control_register = 16'h0000;
    logic [6:0] acc_reg_index;
    int miscompares = 0;
    int num_checks = 0;
    always #5 mclk = ~mclk;

    pcih_config_header i_pcih_config_header (.mclk(mclk), .reset_n(reset_n),
        .cfg_req(cfg_req), .cfg_write(cfg_write), .cfg_dword(cfg_dword),
        .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
        .cfg_claim(cfg_claim), .cfg_rdata(cfg_rdata), .eeprom_load(eeprom_load),
        .eeprom_revision(eeprom_revision), .eeprom_class(eeprom_class),
        .local_control_register(local_control_register), .acc_valid(acc_valid),
        .acc_is_io(acc_is_io), .acc_addr(acc_addr), .acc_claim(acc_claim),
        .acc_claim_io(acc_claim_io), .acc_reg_index(acc_reg_index),
        .cfg_memory_base(cfg_memory_base), .cfg_io_base(cfg_io_base));
    pcih_host_model i_pcih_host_model (.mclk(mclk), .cfg_req(cfg_req),
        .cfg_write(cfg_write), .cfg_dword(cfg_dword), .cfg_byte_en(cfg_byte_en),
        .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_claim(cfg_claim),
        .cfg_rdata(cfg_rdata), .acc_valid(acc_valid), .acc_is_io(acc_is_io),
        .acc_addr(acc_addr), .acc_claim(acc_claim), .acc_claim_io(acc_claim_io),
        .acc_reg_index(acc_reg_index));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic rd(input logic [7:2] dw, input logic [31:0] exp);
        i_pcih_host_model.cfg(1'b0, dw, 4'h0, 32'h00000000, d, c, k);
        check("read_ack", {31'h0, k}, 32'h00000001);
        check("read_data", d, exp);
        check("read_claim", {31'h0, c}, {31'h0, dw >= 6'h02 && dw <= 6'h05});
    endtask
    task automatic wr(input logic [7:2] dw, input logic [3:0] be, input logic [31:0] v);
        i_pcih_host_model.cfg(1'b1, dw, be, v, d, c, k);
        check("write_ack", {31'h0, k}, 32'h00000001);
    endtask
    task automatic ta(input logic io, input logic [31:0] a, input logic [31:0] exp);
        i_pcih_host_model.acc(io, a, d);
        check("access", d, exp);
    endtask
    task automatic test_done;
        if (miscompares == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic t_reset;
        rd(6'h02, 32'h06800001);
        rd(6'h03, 32'h00000000);
        rd(6'h04, 32'h00000000);
        rd(6'h05, 32'h00000001);
        check("io_out", cfg_io_base, 32'h00000001);
    endtask
    task automatic t_fixed;
        wr(6'h02, 4'hF, 32'hFFFFFFFF);
        rd(6'h02, 32'h06800001);
        wr(6'h03, 4'hF, 32'hFFFFFFFF);
        rd(6'h03, 32'h000000FF);
        wr(6'h03, 4'hE, 32'h00000000);
        rd(6'h03, 32'h000000FF);
        rd(6'h06, 32'h00000000);
        check("unmapped_claim", {31'h0, c}, 32'h00000000);
    endtask
    task automatic t_ident;
        @(negedge mclk);
        eeprom_load = 1'b1;
        eeprom_revision = 8'h5A;
        eeprom_class = 24'h123456;
        @(negedge mclk);
        eeprom_load = 1'b0;
        rd(6'h02, 32'h1234565A);
    endtask
    task automatic t_bars;
        wr(6'h04, 4'hF, 32'hFFFFFFFF);
        rd(6'h04, 32'hFFFFFF80);
        wr(6'h05, 4'hF, 32'hFFFFFFFF);
        rd(6'h05, 32'hFFFFFF81);
        // bit 7 lives in lane 0, so this clears only the low base bit
        wr(6'h04, 4'h1, 32'h00000000);
        rd(6'h04, 32'hFFFFFF00);
        check("mem_out", cfg_memory_base, 32'hFFFFFF00);
    endtask
    task automatic t_decode;
        wr(6'h04, 4'hF, 32'hA5000080);
        wr(6'h05, 4'hF, 32'h00001200);
        local_control_register = 16'h0000;
        ta(1'b0, 32'hA5000085, 32'h00000000);
        local_control_register = 16'h1000;
        ta(1'b0, 32'hA5000085, 32'h00000105);
        ta(1'b1, 32'hA5000085, 32'h00000005);
        ta(1'b0, 32'hA5000105, 32'h00000005);
        ta(1'b1, 32'h0000127F, 32'h00000005);
        local_control_register = 16'h2000;
        ta(1'b1, 32'h0000127F, 32'h000001FF);
    endtask

    initial begin
        eeprom_load = 1'b0;
        repeat (20) @(negedge mclk);
        reset_n = 1'b1;
        t_reset;
        t_fixed;
        t_ident;
        t_bars;
        t_decode;
        test_done;
    end
    initial begin
        #100000;
        miscompares++;
        test_done;
    end
endmodule

bind pcih_config_header pcih_props #(.WIN_LSB(WIN_LSB)) i_pcih_props (.mclk(mclk),
    .reset_n(reset_n), .cfg_req(cfg_req), .cfg_write(cfg_write), .cfg_dword(cfg_dword),
    .cfg_ack(cfg_ack), .cfg_claim(cfg_claim), .cfg_rdata(cfg_rdata),
    .local_control_register(local_control_register), .acc_valid(acc_valid),
    .acc_is_io(acc_is_io), .acc_addr(acc_addr), .acc_claim(acc_claim),
    .acc_claim_io(acc_claim_io), .acc_reg_index(acc_reg_index),
    .cfg_memory_base(cfg_memory_base), .cfg_io_base(cfg_io_base));
